// >>> pkg/intr_credit_map.svh
// Register offsets, field positions, reset values and credit figures of the interrupt/credit block.
`ifndef INTR_CREDIT_MAP_SVH
`define INTR_CREDIT_MAP_SVH
`define OFS_CMD          12'h000
`define OFS_MSI_CTL      12'h004
`define OFS_INT_REQ      12'h008
`define OFS_STATUS       12'h00c
`define OFS_MASK         12'h010
`define OFS_CFG          12'h014
`define OFS_CRED_HDR     12'h018
`define OFS_CRED_DATA    12'h01c
`define OFS_MODE         12'h020
`define CMD_INTX_DIS_BIT 10
`define MSI_EN_BIT       0
`define CFG_ECRC_BIT     0
`define ST_UR_NP_BIT     0
`define ST_UR_P_BIT      1
`define ST_MSI_BIT       2
`define ST_INTX_BIT      3
`define CPL_ERR_UR_NP    5
`define CPL_ERR_UR_P     4
`define CMD_RST          32'h0000_0000
`define MSI_CTL_RST      32'h0000_0000
`define MASK_RST         4'h0
`define CRED_PH          8'h32
`define CRED_NPH         8'h36
`define CRED_CPLH        8'h70
`define CRED_PD_NOECRC   12'h168
`define CRED_CPLD_NOECRC 12'h1c0
`define CRED_PD_ECRC     12'h150
`define CRED_CPLD_ECRC   12'h1a4
`define RX_BUF_BYTES     16'h4000
`endif

// >>> pkg/intr_credit_pkg.sv
// Types shared by the interrupt selection and receive credit block.
package intr_credit_pkg;
  typedef enum logic [1:0] {
    INT_NONE,
    INT_LEGACY,
    INT_MSI
  } int_mode_t;
endpackage

// >>> design/int_mode_sel.sv
// Interrupt mechanism selector driven by the configuration space control bits.
`timescale 1ns/1ps
`include "intr_credit_map.svh"
module int_mode_sel
  import intr_credit_pkg::*;
(
  // Configuration controls
  input  wire logic [31:0] cmd_reg,
  input  wire logic [31:0] msi_ctl_reg,
  // Selected mechanism
  output int_mode_t        mode
);
  // MSI enable takes priority, so both mechanisms can never be live together.
  always_comb begin
    if (msi_ctl_reg[`MSI_EN_BIT]) begin // see [R3] see [R4]
      mode = INT_MSI;
    end else if (!cmd_reg[`CMD_INTX_DIS_BIT]) begin // see [R2]
      mode = INT_LEGACY;
    end else begin
      mode = INT_NONE;
    end
  end
endmodule

// >>> design/intr_credit_top.sv
// Interrupt selection, error report capture and fixed receive credit allocation with APB registers.
//
// Operation
// [R1] Interrupt type follows only the configuration space interrupt control bits.
// [R2] Command bit 10 set suppresses legacy interrupt signalling.
// [R3] MSI control bit 0 set makes interrupts go out as MSI messages.
// [R4] Legacy and MSI are never active together.
// [R5] Application raises error input bit 5 for non-posted unsupported request.
// [R6] Application raises error input bit 4 for posted unsupported request.
// [R7] Credit allocation is fixed; desired performance setting is ignored.
// [R8] Without ECRC forward: 360 posted data, 448 completion data, 16384 byte buffer.
// [R9] Always 50 posted, 54 non-posted, 112 completion header credits.
// [R10] With ECRC forward: 336 posted, 420 completion data, same buffer.
`timescale 1ns/1ps
`include "intr_credit_map.svh"
module intr_credit_top
  import intr_credit_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Application error reports
  input  wire logic [5:4]  cpl_err,
  // Application interrupt request
  input  wire logic        app_int_req,
  // Link-side interrupt signalling
  output logic             msi_req,
  output logic             intx_assert,
  // Advertised credits
  output logic [7:0]       cred_ph,
  output logic [11:0]      cred_pd,
  output logic [7:0]       cred_nph,
  output logic [7:0]       cred_cplh,
  output logic [11:0]      cred_cpld,
  // Summary interrupt
  output logic             irq
);
  import intr_credit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] cmd_r;
  logic [31:0] msi_ctl_r;
  logic        ecrc_fwd_r;
  logic [3:0]  status_r;
  logic [3:0]  mask_r;
  logic        app_int_q_r;
  int_mode_t   mode;
  logic        wr_en;
  logic        rd_en;
  logic        int_edge;
  logic [3:0]  events;

  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && penable && !pwrite;
  assign int_edge = app_int_req && !app_int_q_r;

  int_mode_sel u_sel (
    .cmd_reg     (cmd_r),
    .msi_ctl_reg (msi_ctl_r),
    .mode        (mode)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration controls, written by host configuration software.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r      <= `CMD_RST;
      msi_ctl_r  <= `MSI_CTL_RST;
      ecrc_fwd_r <= 1'b0;
      mask_r     <= `MASK_RST;
    end else if (wr_en) begin
      if (hit(paddr, `OFS_CMD)) begin
        cmd_r <= pwdata;
      end
      if (hit(paddr, `OFS_MSI_CTL)) begin
        msi_ctl_r <= pwdata;
      end
      if (hit(paddr, `OFS_CFG)) begin
        ecrc_fwd_r <= pwdata[`CFG_ECRC_BIT];
      end
      if (hit(paddr, `OFS_MASK)) begin
        mask_r <= pwdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The request input is sampled once; it comes from logic on this clock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      app_int_q_r <= 1'b0;
    end else begin
      app_int_q_r <= app_int_req;
    end
  end

  // Mechanism choice depends only on the two configuration registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_req     <= 1'b0;
      intx_assert <= 1'b0;
    end else begin
      msi_req     <= int_edge && (mode == INT_MSI); // see [R1] see [R3]
      intx_assert <= app_int_req && (mode == INT_LEGACY); // see [R1] see [R2] see [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a new event wins over the clear done by a status read.
  always_comb begin
    events = 4'h0;
    events[`ST_UR_NP_BIT] = cpl_err[`CPL_ERR_UR_NP]; // see [R5]
    events[`ST_UR_P_BIT]  = cpl_err[`CPL_ERR_UR_P]; // see [R6]
    events[`ST_MSI_BIT]   = int_edge && (mode == INT_MSI);
    events[`ST_INTX_BIT]  = int_edge && (mode == INT_LEGACY);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 4'h0;
    end else if (rd_en && hit(paddr, `OFS_STATUS)) begin
      // Only the bits already returned in prdata are cleared, so an event landing at setup is kept.
      status_r <= (status_r & ~prdata[3:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Header credits are constants, data credits follow only the ECRC forward bit; no performance setting is consulted.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cred_ph   <= `CRED_PH;
      cred_nph  <= `CRED_NPH;
      cred_cplh <= `CRED_CPLH;
      cred_pd   <= `CRED_PD_NOECRC;
      cred_cpld <= `CRED_CPLD_NOECRC;
    end else begin
      cred_ph   <= `CRED_PH; // see [R7] see [R9]
      cred_nph  <= `CRED_NPH; // see [R9]
      cred_cplh <= `CRED_CPLH; // see [R9]
      if (ecrc_fwd_r) begin
        cred_pd   <= `CRED_PD_ECRC; // see [R10]
        cred_cpld <= `CRED_CPLD_ECRC; // see [R10]
      end else begin
        cred_pd   <= `CRED_PD_NOECRC; // see [R8]
        cred_cpld <= `CRED_CPLD_NOECRC; // see [R8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answers in the setup-following access cycle: no wait states.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        pslverr <= paddr[11:6] != 6'h00 || paddr[5:0] > `OFS_MODE;
        if (!pwrite) begin
          case (paddr)
            `OFS_CMD:       prdata <= cmd_r;
            `OFS_MSI_CTL:   prdata <= msi_ctl_r;
            `OFS_INT_REQ:   prdata <= {31'h0, app_int_req};
            `OFS_STATUS:    prdata <= {28'h0, status_r};
            `OFS_MASK:      prdata <= {28'h0, mask_r};
            `OFS_CFG:       prdata <= {31'h0, ecrc_fwd_r};
            `OFS_CRED_HDR:  prdata <= {8'h00, cred_cplh, cred_nph, cred_ph};
            `OFS_CRED_DATA: prdata <= {4'h0, cred_cpld, 4'h0, cred_pd};
            `OFS_MODE:      prdata <= {30'h0, mode};
            default:        prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end
endmodule

// >>> sim/app_model.sv
// Behavioural application logic that raises interrupts and error reports.
`timescale 1ns/1ps
module app_model (
  // Clock
  input  wire logic       clk,
  // Requests into the block
  output logic            app_int_req,
  output logic      [5:4] cpl_err
);
  initial begin
    app_int_req = 1'b0;
    cpl_err = 2'h0;
  end
  task automatic raise_int();
    @(posedge clk) app_int_req <= 1'b1;
    repeat (3) @(posedge clk);
    app_int_req <= 1'b0;
  endtask
  // Every high cycle counts as one report, so a report lasts one cycle only.
  task automatic report(input logic [5:4] e);
    @(posedge clk) cpl_err <= e;
    @(posedge clk) cpl_err <= 2'h0;
  endtask
endmodule

// >>> sim/intr_credit_monitor.sv
// Port-level assertions for the interrupt selection and credit block.
`timescale 1ns/1ps
`include "intr_credit_map.svh"
module intr_credit_monitor (
  // Clock, reset and interrupts
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        app_int_req,
  input  wire logic        msi_req,
  input  wire logic        intx_assert,
  // Credits
  input  wire logic [7:0]  cred_ph,
  input  wire logic [7:0]  cred_nph,
  input  wire logic [7:0]  cred_cplh,
  input  wire logic [11:0] cred_pd,
  input  wire logic [11:0] cred_cpld
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence msi_once;
    msi_req ##1 !msi_req;
  endsequence
  hdr_cred_a: assert property (cred_ph == `CRED_PH && cred_nph == `CRED_NPH && cred_cplh == `CRED_CPLH)
    else $error("header credits wrong");
  plain_data_a: assert property (cred_pd == `CRED_PD_NOECRC |-> cred_cpld == `CRED_CPLD_NOECRC)
    else $error("data credits wrong");
  ecrc_data_a: assert property (cred_pd == `CRED_PD_ECRC |-> cred_cpld == `CRED_CPLD_ECRC)
    else $error("ecrc data credits wrong");
  fixed_alloc_a: assert property (cred_pd == `CRED_PD_NOECRC || cred_pd == `CRED_PD_ECRC)
    else $error("credit allocation not fixed");
  one_type_a: assert property (!(msi_req && intx_assert))
    else $error("both interrupt types active");
  msi_cause_a: assert property (msi_req |-> $past(app_int_req) && !$past(app_int_req, 2))
    else $error("message without request edge");
  msi_pulse_a: assert property (msi_req |-> msi_once)
    else $error("message request too long");
  intx_cause_a: assert property (intx_assert |-> $past(app_int_req))
    else $error("legacy line without request");
endmodule
bind intr_credit_top intr_credit_monitor i_mon (.*);

// >>> sim/intr_credit_top_test.sv
// Self-checking bench for the interrupt selection and credit block.
`timescale 1ns/1ps
`include "intr_credit_map.svh"
module intr_credit_top_test;
  import intr_credit_pkg::*;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, c, m;
  logic        pready, pslverr, app_int_req, msi_req, intx_assert, irq, err;
  logic [5:4]  cpl_err;
  logic [7:0]  cred_ph, cred_nph, cred_cplh;
  logic [11:0] cred_pd, cred_cpld;
  int          n_mismatch = 0, checked = 0, seed = 96388, n_msi = 0, n_intx = 0, k, j;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    n_msi <= n_msi + 32'(msi_req === 1'b1);
    n_intx <= n_intx + 32'(intx_assert === 1'b1);
  end
  intr_credit_top i_dut (.*);
  app_model i_app (.clk(clk), .app_int_req(app_int_req), .cpl_err(cpl_err));
  function automatic logic [31:0] exp_mode(logic [31:0] cm, logic [31:0] ms);
    return ms[`MSI_EN_BIT] ? {30'h0, INT_MSI} : cm[`CMD_INTX_DIS_BIT] ? {30'h0, INT_NONE} : {30'h0, INT_LEGACY};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held from setup until pready is sampled high at a rising edge.
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk("pd", 32'(`CRED_PD_NOECRC), 32'(cred_pd));
    chk("cpld", 32'(`CRED_CPLD_NOECRC), 32'(cred_cpld));
    apb(1, `OFS_CFG, 32'h1);
    apb(0, `OFS_CRED_DATA, 32'h0);
    chk("data", {4'h0, `CRED_CPLD_ECRC, 4'h0, `CRED_PD_ECRC}, rd);
    apb(0, `OFS_CRED_HDR, 32'h0);
    chk("hdr", {8'h0, `CRED_CPLH, `CRED_NPH, `CRED_PH}, rd);
    apb(1, `OFS_CFG, 32'h0);
    apb(1, `OFS_MASK, 32'hf);
    for (int i = 0; i < 12; i++) begin
      c = (i < 4) ? {21'h0, i[1], 10'h0} : $random(seed);
      m = (i < 4) ? {31'h0, i[0]} : $random(seed);
      apb(1, `OFS_CMD, c);
      apb(1, `OFS_MSI_CTL, m);
      apb(0, `OFS_MODE, 32'h0);
      chk("mode", exp_mode(c, m), rd);
      k = n_msi; j = n_intx;
      i_app.raise_int();
      repeat (2) @(posedge clk);
      chk("msi", {31'h0, exp_mode(c, m) == 2}, 32'(n_msi - k));
      chk("intx", {31'h0, exp_mode(c, m) == 1}, {31'h0, n_intx != j});
      apb(0, `OFS_STATUS, 32'h0);
      chk("st", {28'h0, exp_mode(c, m) == 1, exp_mode(c, m) == 2, 2'h0}, rd);
    end
    for (int i = 0; i < 3; i++) begin
      if (i == 2) apb(1, `OFS_MASK, 32'h0);
      i_app.report(i == 0 ? 2'b01 : 2'b10);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, i != 2}, {31'h0, irq});
      apb(0, `OFS_STATUS, 32'h0);
      chk("ur", i == 0 ? 32'h2 : 32'h1, rd);
    end
    apb(0, `OFS_STATUS, 32'h0);
    chk("clr", 32'h0, rd);
    apb(0, 12'h040, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    wrap_up();
  end
endmodule
